// File: rtl/bert_ctrl_pkg.sv
// constants for the pattern and interface control block
// assumes a byte-wide register port with a 4-bit address
package bert_ctrl_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] WORD4_OFFSET  = 4'h2;
  localparam logic [3:0] WORD3_OFFSET  = 4'h3;
  localparam logic [3:0] WORD2_OFFSET  = 4'h4;
  localparam logic [3:0] WORD1_OFFSET  = 4'h5;
  localparam logic [3:0] STATUS_OFFSET = 4'hC;

  // control and status register fields
  localparam int PAT_MSB     = 7;
  localparam int PAT_LSB     = 4;
  localparam int SOFT_RST    = 3;
  localparam int TX_INVERT   = 2;
  localparam int IFACE_MSB   = 1;
  localparam int IFACE_LSB   = 0;
  localparam int STAT_MISS   = 0;
  localparam int STAT_EMPTY  = 1;

  // reset values
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] WORD_RESET    = 8'h00;
  localparam logic [7:0] SOFT_RST_HOLD = 8'h08;
  localparam logic [7:0] RDATA_UNMAP   = 8'h00;

  // link geometry
  localparam int HIST_W     = 32;
  localparam int SYNC_DEPTH = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int ZS_RUN     = 14;

  // interface select codes
  typedef enum logic [1:0] {
    IFACE_SERIAL   = 2'b00,
    IFACE_NIBBLE   = 2'b01,
    IFACE_RESERVED = 2'b10,
    IFACE_BYTE     = 2'b11
  } iface_e;

  // pattern select codes
  typedef enum logic [3:0] {
    PAT_ZEROS  = 4'b0000,
    PAT_ONES   = 4'b0001,
    PAT_ALT    = 4'b0010,
    PAT_DALT   = 4'b0011,
    PAT_USER1  = 4'b0100,
    PAT_USER2  = 4'b0101,
    PAT_USER3  = 4'b0110,
    PAT_USER4  = 4'b0111,
    PAT_PRBS15 = 4'b1000,
    PAT_QRSS20 = 4'b1001,
    PAT_PRBS20 = 4'b1010,
    PAT_PRBS23 = 4'b1011
  } pattern_e;

  // seeds for the repeating fixed words and the shift registers
  localparam logic [31:0] SEED_ALT  = 32'hAAAA_AAAA;
  localparam logic [31:0] SEED_DALT = 32'hCCCC_CCCC;
  localparam logic [31:0] SEED_PRBS = 32'hFFFF_FFFF;
  localparam logic [31:0] SEED_NONE = 32'h0000_0000;

  // per-mode lane masks and lane bit counts
  localparam logic [7:0] MASK_SERIAL = 8'h01;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] MASK_BYTE   = 8'hFF;
  localparam logic [3:0] BITS_SERIAL = 4'h1;
  localparam logic [3:0] BITS_NIBBLE = 4'h4;
  localparam logic [3:0] BITS_BYTE   = 4'h8;
endpackage

// File: rtl/bert_pattern_mode_control.sv
// pattern select, soft reset, transmit inversion and interface select of a
// bit error rate generator/receiver, with its generator and detector
// assumes link clocks far slower than mclk_in; both are sampled as plain inputs
`timescale 1ns/10ps
// Functional notes
// RULE1: codes 0000-0011 give all zeros, all ones, alternating 10, and 1100.
// RULE2: codes 0100-0111 use user bytes 1..4; 1000-1011 select pseudo-random sequences.
// RULE3: code 1001 is the zero-suppressed 2^20-1 variant, generated and checked.
// RULE4: host must not combine zero-suppressed pattern with byte interface.
// RULE5: one pattern selection drives both generator and detector together.
// RULE6: writing one to control bit 3 resets the whole block.
// RULE7: host releases the reset by writing zero to bit 3.
// RULE8: soft reset clears generator, detector, fifo, control bits and status.
// RULE9: host rewrites every read/write bit after a reset.
// RULE10: control bit 2 inverts all transmitted bits in every interface mode.
// RULE11: bits 1:0 pick serial 00, nibble 01, byte 11 for both directions.
// RULE12: interface code 10 keeps previous mode; pattern codes 1100-1111 idle the logic.
module bert_pattern_mode_control #(
  parameter int FIFO_WORDS = bert_ctrl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                              mclk_in,
  input  wire logic                              rst_in,
  // register port
  input  wire logic [bert_ctrl_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [bert_ctrl_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output logic [bert_ctrl_pkg::DATA_W-1:0]       rdata_out,
  // transmit link
  input  wire logic                              tx_clk_in,
  output logic [7:0]                             tx_data_out,
  // receive link
  input  wire logic                              rx_clk_in,
  input  wire logic [7:0]                        rx_data_in,
  output logic                                   rx_error_out
);
  import bert_ctrl_pkg::*;

  initial begin
    if (FIFO_WORDS < 2 || (FIFO_WORDS & (FIFO_WORDS - 1)) != 0) begin
      $error("bert_pattern_mode_control: FIFO_WORDS must be a power of two");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic [3:0] lane_bits(input logic [1:0] mode);
    case (mode)
      IFACE_NIBBLE: lane_bits = BITS_NIBBLE;
      IFACE_BYTE:   lane_bits = BITS_BYTE;
      default:      lane_bits = BITS_SERIAL;
    endcase
  endfunction

  function automatic logic pattern_legal(input logic [3:0] pat);
    pattern_legal = (pat <= PAT_PRBS23);
  endfunction

  // next bit of the selected pattern from the history, newest bit at index 0
  function automatic logic pat_bit(input logic [31:0] h, input logic [3:0] pat);
    case (pat)
      PAT_ZEROS:  pat_bit = 1'b0;
      PAT_ONES:   pat_bit = 1'b1;
      PAT_ALT:    pat_bit = h[1];
      PAT_DALT:   pat_bit = h[3];
      PAT_USER1:  pat_bit = h[7];
      PAT_USER2:  pat_bit = h[15];
      PAT_USER3:  pat_bit = h[23];
      PAT_USER4:  pat_bit = h[31];
      PAT_PRBS15: pat_bit = h[14] ^ h[13];
      PAT_QRSS20: pat_bit = h[19] ^ h[16];
      PAT_PRBS20: pat_bit = h[19] ^ h[2];
      PAT_PRBS23: pat_bit = h[22] ^ h[17];
      default:    pat_bit = 1'b0;
    endcase
  endfunction

  // advance the generator by n bits, first bit in the top used lane
  function automatic logic [39:0] gen_step(input logic [31:0] h, input logic [3:0] pat,
                                           input logic [3:0] n);
    logic [31:0] hh;
    logic [7:0]  w;
    logic        b;
    logic        ob;
    logic [3:0]  pos;
    hh = h;
    w  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b   = pat_bit(hh, pat);
      // zero suppression: a long run of zeros is broken by a forced one
      ob  = b | ((pat == PAT_QRSS20) && (hh[ZS_RUN-1:0] == '0)); // RULE3
      pos = n - 4'(i) - 4'h1;
      if (4'(i) < n) begin
        w[pos[2:0]] = ob;
        hh = {hh[30:0], b};
      end
    end
    gen_step = {hh, w};
  endfunction

  // check n received bits against the prediction, shifting received bits in
  function automatic logic [32:0] det_step(input logic [31:0] h, input logic [3:0] pat,
                                           input logic [3:0] n, input logic [7:0] w);
    logic [31:0] hh;
    logic        err;
    logic        rb;
    logic        eb;
    logic        pb;
    logic        zs;
    logic [3:0]  pos;
    hh  = h;
    err = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pos = n - 4'(i) - 4'h1;
      rb  = w[pos[2:0]];
      pb  = pat_bit(hh, pat);
      // a forced one hides the true sequence bit, so the prediction stands in for it;
      // an all-zero history is the lock-up state and always learns from the line
      zs  = (pat == PAT_QRSS20) && (hh[ZS_RUN-1:0] == '0) && (hh[19:0] != '0);
      eb  = pb | zs; // RULE3
      if (4'(i) < n) begin
        err = err | (rb != eb);
        hh  = {hh[30:0], (zs ? pb : rb)};
      end
    end
    det_step = {hh, err};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] ctrl;
  logic [7:0] word1;
  logic [7:0] word2;
  logic [7:0] word3;
  logic [7:0] word4;
  logic       miss_sticky;
  logic       reload;

  wire logic [3:0] pattern    = ctrl[PAT_MSB:PAT_LSB];
  wire logic       soft_reset = ctrl[SOFT_RST];
  wire logic       tx_invert  = ctrl[TX_INVERT];
  wire logic [1:0] iface_sel  = ctrl[IFACE_MSB:IFACE_LSB];
  wire logic [3:0] lane_n     = lane_bits(iface_sel); // RULE11
  wire logic       pat_run    = pattern_legal(pattern) && !soft_reset; // RULE12

  wire logic wr_ctrl   = wr_in && (addr_in == CTRL_OFFSET);
  wire logic wr_word   = wr_in && ((addr_in == WORD1_OFFSET) || (addr_in == WORD2_OFFSET) ||
                                   (addr_in == WORD3_OFFSET) || (addr_in == WORD4_OFFSET));
  wire logic rd_status = rd_in && (addr_in == STATUS_OFFSET);
  wire logic set_reset = wr_ctrl && wdata_in[SOFT_RST]; // RULE6
  wire logic [1:0] w_iface = wdata_in[IFACE_MSB:IFACE_LSB];
  // reserved interface code keeps the mode already in force
  wire logic [1:0] kept_iface = (w_iface == IFACE_RESERVED) ? iface_sel : w_iface; // RULE12
  wire logic [7:0] next_ctrl  = set_reset ? SOFT_RST_HOLD : {wdata_in[7:2], kept_iface}; // RULE8

  logic det_err;
  logic det_fire;
  logic fifo_empty;

  wire logic [7:0] rd_mux =
      (addr_in == CTRL_OFFSET)   ? ctrl :
      (addr_in == WORD1_OFFSET)  ? word1 :
      (addr_in == WORD2_OFFSET)  ? word2 :
      (addr_in == WORD3_OFFSET)  ? word3 :
      (addr_in == WORD4_OFFSET)  ? word4 :
      (addr_in == STATUS_OFFSET) ? {6'h00, fifo_empty, miss_sticky} : RDATA_UNMAP;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl  <= CTRL_RESET;
      word1 <= WORD_RESET;
      word2 <= WORD_RESET;
      word3 <= WORD_RESET;
      word4 <= WORD_RESET;
    end else if (set_reset) begin
      ctrl  <= next_ctrl; // RULE8
      word1 <= WORD_RESET;
      word2 <= WORD_RESET;
      word3 <= WORD_RESET;
      word4 <= WORD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_in && addr_in == WORD1_OFFSET) begin
        word1 <= wdata_in;
      end
      if (wr_in && addr_in == WORD2_OFFSET) begin
        word2 <= wdata_in;
      end
      if (wr_in && addr_in == WORD3_OFFSET) begin
        word3 <= wdata_in;
      end
      if (wr_in && addr_in == WORD4_OFFSET) begin
        word4 <= wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out   <= RDATA_UNMAP;
      miss_sticky <= 1'b0;
      reload      <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_mux : RDATA_UNMAP;
      reload    <= wr_ctrl || wr_word;
      // a new mismatch wins over the clear-on-read
      if (det_fire && det_err) begin
        miss_sticky <= 1'b1;
      end else if (rd_status || soft_reset) begin
        miss_sticky <= 1'b0; // RULE8
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link input synchronisers and edge detection

  logic [SYNC_DEPTH-1:0] tx_clk_sync;
  logic [SYNC_DEPTH-1:0] rx_clk_sync;
  logic [7:0]            rx_data_meta;
  logic [7:0]            rx_data_sync;
  logic                  tx_clk_last;
  logic                  rx_clk_last;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_clk_sync  <= '0;
      rx_clk_sync  <= '0;
      rx_data_meta <= 8'h00;
      rx_data_sync <= 8'h00;
      tx_clk_last  <= 1'b0;
      rx_clk_last  <= 1'b0;
    end else begin
      tx_clk_sync  <= {tx_clk_sync[0], tx_clk_in};
      rx_clk_sync  <= {rx_clk_sync[0], rx_clk_in};
      rx_data_meta <= rx_data_in;
      rx_data_sync <= rx_data_meta;
      tx_clk_last  <= tx_clk_sync[1];
      rx_clk_last  <= rx_clk_sync[1];
    end
  end

  wire logic tx_rise = tx_clk_sync[1] && !tx_clk_last;
  wire logic rx_rise = rx_clk_sync[1] && !rx_clk_last;

  //////////////////////////////////////////////////////////////////////////////
  // pattern generator feeding the transmit fifo

  logic [31:0] gen_hist;
  logic [31:0] det_hist;

  wire logic [31:0] seed_hist =
      (pattern == PAT_ALT)   ? SEED_ALT :
      (pattern == PAT_DALT)  ? SEED_DALT :
      (pattern == PAT_USER1) ? {24'h00_0000, word1} :
      (pattern == PAT_USER2) ? {16'h0000, word1, word2} :
      (pattern == PAT_USER3) ? {8'h00, word1, word2, word3} :
      (pattern == PAT_USER4) ? {word1, word2, word3, word4} :
      pattern[3]             ? SEED_PRBS : SEED_NONE; // RULE2

  wire logic [39:0] gen_next   = gen_step(gen_hist, pattern, lane_n); // RULE1 RULE2 RULE5
  wire logic        fifo_flush = reload || soft_reset; // RULE8
  wire logic        gen_valid  = pat_run && !reload;
  logic             gen_ready;
  logic             tx_valid;
  logic [7:0]       tx_word;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gen_hist <= SEED_NONE;
    end else if (reload || soft_reset) begin
      gen_hist <= seed_hist; // RULE8
    end else if (gen_valid && gen_ready) begin
      gen_hist <= gen_next[39:8];
    end
  end

  word_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_WORDS)
  ) tx_fifo (
    .clk_in        (mclk_in),
    .rst_in        (rst_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (gen_valid),
    .in_ready_out  (gen_ready),
    .in_data_in    (gen_next[7:0]),
    .out_valid_out (tx_valid),
    .out_ready_in  (tx_rise),
    .out_data_out  (tx_word)
  );

  assign fifo_empty = !tx_valid;

  //////////////////////////////////////////////////////////////////////////////
  // transmit output stage

  wire logic [7:0] lane_mask =
      (iface_sel == IFACE_BYTE)   ? MASK_BYTE :
      (iface_sel == IFACE_NIBBLE) ? MASK_NIBBLE : MASK_SERIAL; // RULE11
  wire logic [7:0] tx_inv_mask = tx_invert ? lane_mask : 8'h00;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_data_out <= 8'h00;
    end else if (soft_reset) begin
      tx_data_out <= 8'h00;
    end else if (tx_rise && tx_valid) begin
      tx_data_out <= (tx_word ^ tx_inv_mask) & lane_mask; // RULE10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive detector; it tracks the received stream so it aligns by itself

  wire logic [32:0] det_next = det_step(det_hist, pattern, lane_n, rx_data_sync); // RULE5
  assign det_err  = det_next[0];
  assign det_fire = rx_rise && pat_run; // RULE12

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      det_hist     <= SEED_NONE;
      rx_error_out <= 1'b0;
    end else if (soft_reset) begin
      det_hist     <= SEED_NONE; // RULE8
      rx_error_out <= 1'b0;
    end else begin
      rx_error_out <= det_fire && det_err;
      if (det_fire) begin
        det_hist <= det_next[32:1];
      end
    end
  end
endmodule

// File: rtl/word_fifo.sv
// synchronous word fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset and a synchronous flush
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("word_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   fill;

  wire logic push = in_valid_in && in_ready_out;
  wire logic pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (fill != DEPTH[PTR_W:0]);
  assign out_valid_out = (fill != '0);
  assign out_data_out  = store[rd_ptr];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end
endmodule

// File: verif/bert_ctrl_asserts.sv
// checker for the pattern and interface control block
// assumes it is bound to bert_pattern_mode_control and sees only its ports
`timescale 1ns/10ps
module bert_ctrl_asserts #(
  parameter int FIFO_WORDS = bert_ctrl_pkg::FIFO_DEPTH
) (
  input wire logic                             mclk_in,
  input wire logic                             rst_in,
  input wire logic [bert_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [bert_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic                             wr_in,
  input wire logic                             rd_in,
  input wire logic [bert_ctrl_pkg::DATA_W-1:0] rdata_out,
  input wire logic                             tx_clk_in,
  input wire logic [7:0]                       tx_data_out,
  input wire logic                             rx_clk_in,
  input wire logic [7:0]                       rx_data_in,
  input wire logic                             rx_error_out
);
  import bert_ctrl_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_sh;
  logic       tx_seen;
  logic       rx_seen;
  logic [3:0] since_tx;
  logic [3:0] since_rx;
  wire        ctrl_wr = wr_in && addr_in == CTRL_OFFSET;
  wire        mapped  = addr_in inside {CTRL_OFFSET, WORD4_OFFSET, WORD3_OFFSET, WORD2_OFFSET, WORD1_OFFSET,
                                        STATUS_OFFSET};
  wire [1:0]  next_iface = (wdata_in[1:0] == IFACE_RESERVED) ? ctrl_sh[1:0] : wdata_in[1:0];
  wire [7:0]  next_ctrl_sh = wdata_in[SOFT_RST] ? SOFT_RST_HOLD : {wdata_in[7:2], next_iface};
  // cycles since the raw link clock was last seen rising
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_sh  <= CTRL_RESET;
      tx_seen  <= 1'b0;
      rx_seen  <= 1'b0;
      since_tx <= 4'hF;
      since_rx <= 4'hF;
    end else begin
      if (ctrl_wr) ctrl_sh <= next_ctrl_sh;
      tx_seen  <= tx_clk_in;
      rx_seen  <= rx_clk_in;
      since_tx <= (tx_clk_in && !tx_seen) ? 4'h0 : since_tx + {3'h0, since_tx != 4'hF};
      since_rx <= (rx_clk_in && !rx_seen) ? 4'h0 : since_rx + {3'h0, since_rx != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rdata_idle;
    !$past(rd_in) |-> rdata_out == RDATA_UNMAP;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    $past(rd_in) && !$past(mapped) |-> rdata_out == RDATA_UNMAP;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_read;
    $past(rd_in) && $past(addr_in) == CTRL_OFFSET |-> rdata_out == $past(ctrl_sh);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
  property p_soft_read;
    ctrl_wr && wdata_in[SOFT_RST] ##1 !wr_in ##1 rd_in && addr_in == CTRL_OFFSET |=> rdata_out == SOFT_RST_HOLD;
  endproperty
  a_soft_read: assert property (p_soft_read) else $error("soft reset not held");
  property p_srst_quiet;
    ctrl_sh[SOFT_RST] && $past(ctrl_sh[SOFT_RST]) |-> tx_data_out == 8'h00 && !rx_error_out;
  endproperty
  a_srst_quiet: assert property (p_srst_quiet) else $error("link active in soft reset");
  property p_err_pulse;
    rx_error_out |=> !rx_error_out;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");
  property p_err_cause;
    rx_error_out |-> since_rx inside {[1:8]};
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error pulse without rx edge");
  property p_tx_cause;
    $changed(tx_data_out) && !ctrl_sh[SOFT_RST] && !$past(ctrl_sh[SOFT_RST]) && !$past(ctrl_sh[SOFT_RST], 2)
      |-> since_tx inside {[1:8]};
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx word moved without tx edge");
  property p_resv_quiet;
    rx_error_out |-> !(ctrl_sh[7:6] == 2'b11 && $past(ctrl_sh[7:6], 3) == 2'b11);
  endproperty
  a_resv_quiet: assert property (p_resv_quiet) else $error("checking in reserved pattern");
  c_soft: cover property (ctrl_wr && wdata_in[SOFT_RST]);
  c_err: cover property (rx_error_out);
  c_resv: cover property (ctrl_wr && wdata_in[1:0] == IFACE_RESERVED);
  c_read: cover property (rd_in ##1 rdata_out != 8'h00);
endmodule
bind bert_pattern_mode_control bert_ctrl_asserts #(.FIFO_WORDS(FIFO_WORDS)) i_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .tx_clk_in(tx_clk_in), .tx_data_out(tx_data_out), .rx_clk_in(rx_clk_in),
  .rx_data_in(rx_data_in), .rx_error_out(rx_error_out)
);

// File: verif/bert_pattern_mode_control_test.sv
// self-checking bench for the pattern and interface control block
// assumes link_partner loops the transmit lanes back onto the receive lanes
`timescale 1ns/10ps
module bert_pattern_mode_control_test;
  import bert_ctrl_pkg::*;
  logic       mclk, rst, wr, rd, run, inject, link_clk, rx_error;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, tx_data, rx_data;
  int         n_errors, n_checks, n_rx_err;
  logic [15:0] pat_tab [10] = '{16'h1001, 16'h0000, 16'h110F, 16'h13FF, 16'h1700, 16'h050F, 16'h0401,
                                16'h23AA, 16'h33CC, 16'h435A};
  // zero-suppressed code is never paired with byte lanes
  logic [7:0] prbs_tab [5] = '{8'h83, 8'hA3, 8'h91, 8'hB3, 8'h80};
  ////////////////////////////////////////////////////////////////////////////
  bert_pattern_mode_control #(.FIFO_WORDS(FIFO_DEPTH)) i_dut (
    .mclk_in(mclk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .tx_clk_in(link_clk), .tx_data_out(tx_data), .rx_clk_in(link_clk), .rx_data_in(rx_data),
    .rx_error_out(rx_error)
  );
  link_partner i_link (
    .run_in(run), .inject_in(inject), .tx_data_in(tx_data), .link_clk_out(link_clk), .rx_data_out(rx_data)
  );
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (rx_error === 1'b1) n_rx_err++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    chk("read data", exp, rdata);
  endtask
  task automatic link_wait(input int n);
    repeat (n) @(posedge link_clk);
    @(negedge link_clk);
  endtask
  task automatic chk_errs(input logic [7:0] exp);
    chk("rx errors", exp, (n_rx_err == 0) ? 8'h00 : 8'h01);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    {mclk, wr, rd, run, inject, addr, wdata} = '0;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    run <= 1'b1;
    rd_chk(CTRL_OFFSET, CTRL_RESET);
    rd_chk(4'h1, RDATA_UNMAP);
    wr_reg(CTRL_OFFSET, 8'h83);
    rd_chk(CTRL_OFFSET, 8'h83);
    wr_reg(CTRL_OFFSET, 8'h82);
    rd_chk(CTRL_OFFSET, 8'h83);
    wr_reg(WORD1_OFFSET, 8'h5A);
    rd_chk(WORD1_OFFSET, 8'h5A);
    $display("test registers done");
    foreach (pat_tab[i]) begin
      wr_reg(CTRL_OFFSET, pat_tab[i][15:8]);
      link_wait(6);
      chk("tx data", pat_tab[i][7:0], tx_data);
    end
    $display("test fixed words done");
    foreach (prbs_tab[i]) begin
      wr_reg(CTRL_OFFSET, prbs_tab[i]);
      link_wait(40);
      n_rx_err = 0;
      link_wait(20);
      chk_errs(8'h00);
    end
    inject <= 1'b1;
    link_wait(10);
    inject <= 1'b0;
    chk_errs(8'h01);
    link_wait(40);
    rd_chk(STATUS_OFFSET, 8'h01);
    rd_chk(STATUS_OFFSET, 8'h00);
    $display("test pseudo-random done");
    wr_reg(CTRL_OFFSET, 8'h13);
    link_wait(6);
    wr_reg(CTRL_OFFSET, 8'hC3);
    inject <= 1'b1;
    link_wait(4);
    n_rx_err = 0;
    link_wait(10);
    chk_errs(8'h00);
    chk("tx data", 8'hFF, tx_data);
    inject <= 1'b0;
    $display("test reserved done");
    wr_reg(CTRL_OFFSET, 8'h18);
    rd_chk(CTRL_OFFSET, SOFT_RST_HOLD);
    link_wait(3);
    chk("tx data", 8'h00, tx_data);
    rd_chk(WORD1_OFFSET, WORD_RESET);
    rd_chk(STATUS_OFFSET, 8'h02);
    wr_reg(CTRL_OFFSET, 8'h13);
    rd_chk(CTRL_OFFSET, 8'h13);
    link_wait(6);
    chk("tx data", 8'hFF, tx_data);
    $display("test soft reset done");
    finish_test();
  end
endmodule

// File: verif/link_partner.sv
// link under test: makes the shared link clock and loops transmit back to receive
// assumes run_in rises once, after the block leaves reset
`timescale 1ns/10ps
module link_partner (
  // control from the bench
  input  wire logic       run_in,
  input  wire logic       inject_in,
  // link pins
  input  wire logic [7:0] tx_data_in,
  output logic            link_clk_out,
  output logic [7:0]      rx_data_out
);
  // clock stands low while idle; offset keeps it apart from mclk
  initial begin
    link_clk_out = 1'b0;
    rx_data_out  = 8'h00;
    #1.3;
    forever begin
      #24;
      link_clk_out = run_in ? ~link_clk_out : 1'b0;
    end
  end
  // data turns at the falling edge, clear of the sampling rise; inject flips lane 0
  always @(negedge link_clk_out) begin
    rx_data_out <= tx_data_in ^ {7'h00, inject_in};
  end
endmodule
